// ==== hdl/modem_mode_cmd.sv ====
// Mode selection, packetiser and configuration command interpreter
//
// Behaviour
// - Low select high and high select low gives general transmission mode.
// - General mode sends host bytes over the air in packets of 55 bytes.
// - General mode starts a transmission when host data arrives and receives when not sending.
// - Low select low and high select high gives configuration mode with register access.
// - Configuration mode sends only remote configuration commands over the air.
// - Configuration mode keeps only remote command answers from the air and drops the rest.
// - Both selects high stops all transmitting and receiving.
// - Configuration mode runs the host link at 9600 baud, 8 data bits, no parity, one stop bit.
// - Command C0 stores parameters persistently and is echoed with C1, address, length, parameters.
// - Command C1 reads registers and is answered with C1, address, length, contents.
// - Command C2 applies parameters temporarily and is echoed like a persistent write.
// - A command behind two CF bytes goes over the air to a remote unit, whose answer is passed back.
// - One access covers length consecutive registers from the start address.
// - A malformed frame is answered with three FF bytes.
// - Both selects low gives continuous transmission with an automatically derived air rate.
`timescale 1ns/1ps
module modem_mode_cmd
  import modem_cfg_pkg::*;
#(
  parameter int NUM_REGS = modem_cfg_pkg::NUM_REGS_DEFAULT,
  parameter int FIFO_DEPTH = modem_cfg_pkg::FIFO_DEPTH_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic mode_select_low_pin,
  input wire logic mode_select_high,
  input wire logic host_rx_valid,
  input wire modem_cfg_pkg::beat_t host_rx,
  output logic host_rx_ready,
  output logic host_tx_valid,
  output modem_cfg_pkg::beat_t host_tx,
  input wire logic host_tx_ready,
  output logic host_baud_fixed,
  output logic air_tx_valid,
  output modem_cfg_pkg::beat_t air_tx,
  input wire logic air_tx_ready,
  input wire logic air_rx_valid,
  input wire modem_cfg_pkg::beat_t air_rx,
  output logic air_rx_ready,
  output logic air_rate_auto,
  output modem_cfg_pkg::mode_t mode,
  output logic [NUM_REGS*8-1:0] live_regs,
  output logic [NUM_REGS*8-1:0] saved_regs
);

  import modem_cfg_pkg::*;

  initial begin
    if (NUM_REGS < 1 || NUM_REGS > 256) begin
      $error("modem_mode_cmd: NUM_REGS must lie in 1..256");
    end
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    parse_t st;
    logic remote;
    logic remote_wait;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] len;
    logic [7:0] cnt;
    logic air_valid;
    beat_t air;
    logic [5:0] pkt;
    logic [NUM_REGS-1:0][7:0] live;
    logic [NUM_REGS-1:0][7:0] saved;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic slot_free;
  logic cfg;
  logic stream;
  logic take;
  logic rsp_active;
  logic air_pass;
  logic fifo_in_valid;
  logic fifo_in_ready;
  beat_t fifo_in;
  beat_t rsp;
  logic [7:0] rd_idx;
  logic [8:0] span;

  // ==========================================================================
  // Mode decode from the synchronised select pins
  always_comb begin
    case (cur.sync2)
      2'b00: mode = MODE_CONT;
      2'b01: mode = MODE_GEN;
      2'b10: mode = MODE_CFG;
      default: mode = MODE_OFF;
    endcase
  end

  assign cfg = (mode == MODE_CFG);
  assign stream = (mode == MODE_GEN) || (mode == MODE_CONT);
  assign host_baud_fixed = cfg;
  assign air_rate_auto = (mode == MODE_CONT);
  assign air_tx_valid = cur.air_valid;
  assign air_tx = cur.air;
  assign live_regs = cur.live;
  assign saved_regs = cur.saved;

  // The one-byte air slot can take a new byte in the cycle it drains
  assign slot_free = !cur.air_valid || air_tx_ready;
  assign rd_idx = cur.addr + cur.cnt;
  assign span = {1'b0, cur.addr} + {1'b0, host_rx.data};

  // ==========================================================================
  // Host receive back-pressure
  always_comb begin
    host_rx_ready = 1'b1;
    if (stream) begin
      host_rx_ready = slot_free;
    end else if (cfg) begin
      case (cur.st)
        P_IDLE, P_PFX: host_rx_ready = 1'b1;
        P_CMD, P_ADDR, P_LEN, P_PARAM: host_rx_ready = !cur.remote || slot_free;
        default: host_rx_ready = 1'b0;
      endcase
    end
  end

  assign take = host_rx_valid && host_rx_ready;

  // ==========================================================================
  // Response byte source
  assign rsp_active = cfg && (cur.st inside {P_RSP_HDR, P_RSP_ADDR, P_RSP_LEN, P_RSP_DATA, P_ERR});

  always_comb begin
    rsp = '{data: ERR_BYTE, last: 1'b0};
    case (cur.st)
      P_RSP_HDR: rsp.data = RSP_HEADER;
      P_RSP_ADDR: rsp.data = cur.addr;
      P_RSP_LEN: rsp.data = cur.len;
      P_RSP_DATA: begin
        rsp.data = cur.live[rd_idx];
        rsp.last = (cur.cnt == cur.len - 8'h01);
      end
      P_ERR: begin
        rsp.data = ERR_BYTE;
        rsp.last = (cur.cnt[1:0] == ERR_LAST);
      end
      default: rsp.data = ERR_BYTE;
    endcase
  end

  // ==========================================================================
  // Air receive path into the host FIFO
  // In configuration mode only an outstanding remote request opens the path
  assign air_pass = stream || (cfg && cur.remote_wait && !rsp_active);

  always_comb begin
    if (air_pass) begin
      air_rx_ready = fifo_in_ready;
    end else begin
      air_rx_ready = cfg;
    end
  end

  assign fifo_in_valid = rsp_active || (air_pass && air_rx_valid);
  assign fifo_in = rsp_active ? rsp : air_rx;

  byte_fifo #(
    .WIDTH($bits(beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_host_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(host_tx_valid),
    .out_ready(host_tx_ready),
    .out_data(host_tx)
  );

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_cur = cur;
    next_cur.sync1 = {mode_select_high, mode_select_low_pin};
    next_cur.sync2 = cur.sync1;
    if (cur.air_valid && air_tx_ready) begin
      next_cur.air_valid = 1'b0;
    end
    if (mode == MODE_OFF) begin
      next_cur.air_valid = 1'b0;
    end

    // Packetised and continuous streaming
    if (stream && take) begin
      next_cur.air_valid = 1'b1;
      next_cur.air.data = host_rx.data;
      next_cur.air.last = host_rx.last;
      if (mode == MODE_GEN && cur.pkt == PACKET_LAST) begin
        next_cur.air.last = 1'b1;
      end
      next_cur.pkt = next_cur.air.last ? 6'h00 : cur.pkt + 6'h01;
    end

    if (air_pass && air_rx_valid && fifo_in_ready && cfg && air_rx.last) begin
      next_cur.remote_wait = 1'b0;
    end

    if (!cfg) begin
      // Leaving configuration mode abandons any frame in progress
      next_cur.st = P_IDLE;
      next_cur.remote = 1'b0;
      next_cur.remote_wait = 1'b0;
    end else begin
      next_cur.pkt = 6'h00;
      case (cur.st)
        P_IDLE: begin
          if (take) begin
            next_cur.remote = 1'b0;
            next_cur.cnt = 8'h00;
            if (host_rx.data == CMD_REMOTE) begin
              next_cur.st = P_PFX;
            end else if (host_rx.data inside {CMD_WRITE, CMD_READ, CMD_TEMP}) begin
              next_cur.cmd = host_rx.data;
              next_cur.st = P_ADDR;
            end else begin
              next_cur.st = P_ERR;
            end
          end
        end
        P_PFX: begin
          if (take) begin
            next_cur.cnt = 8'h00;
            next_cur.st = (host_rx.data == CMD_REMOTE) ? P_FWD : P_ERR;
          end
        end
        P_FWD: begin
          // Replays the two prefix bytes to the air ahead of the command
          if (slot_free) begin
            next_cur.air_valid = 1'b1;
            next_cur.air = '{data: CMD_REMOTE, last: 1'b0};
            next_cur.cnt = cur.cnt + 8'h01;
            if (cur.cnt == 8'h01) begin
              next_cur.remote = 1'b1;
              next_cur.st = P_CMD;
            end
          end
        end
        P_CMD: begin
          if (take) begin
            next_cur.cnt = 8'h00;
            if (host_rx.data inside {CMD_WRITE, CMD_READ, CMD_TEMP}) begin
              next_cur.cmd = host_rx.data;
              next_cur.air_valid = 1'b1;
              next_cur.air = '{data: host_rx.data, last: 1'b0};
              next_cur.st = P_ADDR;
            end else begin
              next_cur.st = P_ERR;
            end
          end
        end
        P_ADDR: begin
          if (take) begin
            next_cur.addr = host_rx.data;
            if (cur.remote) begin
              next_cur.air_valid = 1'b1;
              next_cur.air = '{data: host_rx.data, last: 1'b0};
            end
            next_cur.st = P_LEN;
          end
        end
        P_LEN: begin
          if (take) begin
            next_cur.len = host_rx.data;
            next_cur.cnt = 8'h00;
            if (cur.remote) begin
              next_cur.air_valid = 1'b1;
              next_cur.air = '{data: host_rx.data, last: (cur.cmd == CMD_READ)};
            end
            if (host_rx.data == 8'h00 || (!cur.remote && span > 9'(NUM_REGS))) begin
              next_cur.st = P_ERR;
            end else if (cur.cmd == CMD_READ) begin
              next_cur.remote_wait = cur.remote;
              next_cur.st = cur.remote ? P_IDLE : P_RSP_HDR;
            end else begin
              next_cur.st = P_PARAM;
            end
          end
        end
        P_PARAM: begin
          if (take) begin
            if (cur.remote) begin
              next_cur.air_valid = 1'b1;
              next_cur.air = '{data: host_rx.data, last: (cur.cnt == cur.len - 8'h01)};
            end else begin
              next_cur.live[rd_idx] = host_rx.data;
              if (cur.cmd == CMD_WRITE) begin
                next_cur.saved[rd_idx] = host_rx.data;
              end
            end
            next_cur.cnt = cur.cnt + 8'h01;
            if (cur.cnt == cur.len - 8'h01) begin
              next_cur.cnt = 8'h00;
              next_cur.remote_wait = cur.remote;
              next_cur.st = cur.remote ? P_IDLE : P_RSP_HDR;
            end
          end
        end
        P_RSP_HDR: begin
          if (fifo_in_ready) begin
            next_cur.st = P_RSP_ADDR;
          end
        end
        P_RSP_ADDR: begin
          if (fifo_in_ready) begin
            next_cur.st = P_RSP_LEN;
          end
        end
        P_RSP_LEN: begin
          if (fifo_in_ready) begin
            next_cur.cnt = 8'h00;
            next_cur.st = P_RSP_DATA;
          end
        end
        P_RSP_DATA: begin
          if (fifo_in_ready) begin
            next_cur.cnt = cur.cnt + 8'h01;
            if (rsp.last) begin
              next_cur.st = P_IDLE;
            end
          end
        end
        P_ERR: begin
          if (fifo_in_ready) begin
            next_cur.cnt = cur.cnt + 8'h01;
            if (rsp.last) begin
              next_cur.st = P_IDLE;
            end
          end
        end
        default: next_cur.st = P_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      cur.st <= P_IDLE;
      cur.live <= {NUM_REGS{REG_RESET}};
      cur.saved <= {NUM_REGS{REG_RESET}};
    end else begin
      cur <= next_cur;
    end
  end

endmodule : modem_mode_cmd

// ==== hdl/modem_cfg_pkg.sv ====
// Shared constants and types for the radio modem mode and configuration block
package modem_cfg_pkg;

  // ==========================================================================
  // Command bytes
  localparam logic [7:0] CMD_WRITE = 8'hC0;
  localparam logic [7:0] CMD_READ = 8'hC1;
  localparam logic [7:0] CMD_TEMP = 8'hC2;
  localparam logic [7:0] CMD_REMOTE = 8'hCF;
  localparam logic [7:0] ERR_BYTE = 8'hFF;
  localparam logic [7:0] RSP_HEADER = 8'hC1;

  // ==========================================================================
  // Counts and reset values
  localparam logic [1:0] ERR_LAST = 2'h2;
  localparam logic [5:0] PACKET_LAST = 6'h36;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CFG_BAUD = 9600;
  localparam int NUM_REGS_DEFAULT = 16;
  localparam int FIFO_DEPTH_DEFAULT = 8;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_CONT,
    MODE_GEN,
    MODE_CFG,
    MODE_OFF
  } mode_t;

  typedef enum logic [3:0] {
    P_IDLE,
    P_PFX,
    P_FWD,
    P_CMD,
    P_ADDR,
    P_LEN,
    P_PARAM,
    P_RSP_HDR,
    P_RSP_ADDR,
    P_RSP_LEN,
    P_RSP_DATA,
    P_ERR
  } parse_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } beat_t;

endpackage : modem_cfg_pkg

// ==== hdl/byte_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("byte_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t cur;
  fifo_state_t next_cur;
  logic full;
  logic empty;

  // ==========================================================================
  // Flags
  // Extra pointer bit tells full from empty without a separate counter
  assign full = (cur.wr[AW] != cur.rd[AW]) && (cur.wr[AW-1:0] == cur.rd[AW-1:0]);
  assign empty = (cur.wr == cur.rd);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = cur.mem[cur.rd[AW-1:0]];

  always_comb begin
    next_cur = cur;
    if (in_valid && !full) begin
      next_cur.mem[cur.wr[AW-1:0]] = in_data;
      next_cur.wr = cur.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_cur.rd = cur.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule : byte_fifo

// ==== verif/modem_mode_cmd_monitor.sv ====
// Port-level checker for the mode and configuration block
`timescale 1ns/1ps
module modem_mode_cmd_monitor
  import modem_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic mode_select_low_pin,
  input wire logic mode_select_high,
  input wire logic host_rx_valid,
  input wire modem_cfg_pkg::beat_t host_rx,
  input wire logic host_rx_ready,
  input wire logic host_tx_valid,
  input wire logic host_baud_fixed,
  input wire logic air_tx_valid,
  input wire modem_cfg_pkg::beat_t air_tx,
  input wire logic air_tx_ready,
  input wire logic air_rx_ready,
  input wire logic air_rate_auto,
  input wire modem_cfg_pkg::mode_t mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ========================
  // Air frame tracking
  logic [5:0] pkt_cnt;
  logic air_first;
  wire air_take = air_tx_valid && air_tx_ready;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pkt_cnt <= '0;
      air_first <= 1'b1;
    end else if (air_take) begin
      pkt_cnt <= air_tx.last ? 6'h00 : pkt_cnt + 6'h01;
      air_first <= air_tx.last;
    end
  end
  // ========================
  // Properties
  sequence gen_take;
    mode == MODE_GEN && $past(mode) == MODE_GEN && host_rx_valid && host_rx_ready;
  endsequence
  sequence gen_offer;
    air_tx_valid && air_tx.data == $past(host_rx.data);
  endsequence
  chk_mode_sync: assert property ($past(resetn) && $past(resetn, 2) |->
    mode == mode_t'({$past(mode_select_high, 2), $past(mode_select_low_pin, 2)}))
    else $error("mode does not follow select pins");
  chk_off_no_rx: assert property (mode == MODE_OFF |-> !air_rx_ready)
    else $error("radio data accepted while off");
  chk_off_no_tx: assert property (mode == MODE_OFF && $past(mode) == MODE_OFF |-> !air_tx_valid)
    else $error("radio byte offered while off");
  // In configuration mode the radio may only be held off while answers are queued for the host
  chk_cfg_rx_open: assert property (mode == MODE_CFG && !host_tx_valid |-> air_rx_ready)
    else $error("radio traffic not drained in configuration");
  chk_baud_cfg: assert property (host_baud_fixed == (mode == MODE_CFG))
    else $error("fixed host rate flag wrong");
  chk_rate_auto: assert property (air_rate_auto == (mode == MODE_CONT))
    else $error("automatic air rate flag wrong");
  chk_gen_forward: assert property (gen_take |=> gen_offer)
    else $error("host byte not offered to radio next cycle");
  chk_packet_last: assert property (air_take && mode == MODE_GEN && pkt_cnt == PACKET_LAST |-> air_tx.last)
    else $error("packet longer than limit");
  chk_cfg_remote: assert property (air_take && air_first && mode == MODE_CFG |-> air_tx.data == CMD_REMOTE)
    else $error("non-remote byte sent in configuration");
endmodule : modem_mode_cmd_monitor

bind modem_mode_cmd modem_mode_cmd_monitor monitor_i (.clk_sys, .resetn, .mode_select_low_pin,
  .mode_select_high, .host_rx_valid, .host_rx, .host_rx_ready, .host_tx_valid, .host_baud_fixed, .air_tx_valid,
  .air_tx, .air_tx_ready, .air_rx_ready, .air_rate_auto, .mode);

// ==== verif/air_peer_model.sv ====
// Radio-side model: sinks air bytes, sources received frames
`timescale 1ns/1ps
module air_peer_model
  import modem_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic air_tx_valid,
  input wire modem_cfg_pkg::beat_t air_tx,
  output logic air_tx_ready,
  output logic air_rx_valid,
  output modem_cfg_pkg::beat_t air_rx,
  input wire logic air_rx_ready
);
  logic [8:0] txq[$];
  logic [8:0] rxq[$];
  logic slow = 0;
  initial begin
    air_tx_ready = 0;
    air_rx_valid = 0;
    air_rx = '0;
  end
  // ========================
  // Handshakes, changed just after the edge
  // Judged half a cycle early: nothing moves before the edge, and the design's
  // registered outputs are never read in the time step that launches them
  always @(negedge clk_sys) begin
    if (air_tx_valid && air_tx_ready) txq.push_back(air_tx);
    if (air_rx_valid && air_rx_ready) void'(rxq.pop_front());
  end
  always @(posedge clk_sys) begin
    #1;
    air_tx_ready = resetn && (slow ? !air_tx_ready : 1'b1);
    air_rx_valid = resetn && rxq.size() > 0;
    // Idle lines toggle so a stale byte is never mistaken for data
    air_rx = air_rx_valid ? rxq[0] : ~air_rx;
  end
  task automatic inject(input logic [7:0] b[$]);
    foreach (b[i]) rxq.push_back({b[i], i == b.size() - 1});
  endtask : inject
endmodule : air_peer_model

// ==== verif/modem_mode_cmd_bench.sv ====
// Self-checking bench for the mode and configuration block
`timescale 1ns/1ps
module modem_mode_cmd_bench;
  import modem_cfg_pkg::*;
  typedef logic [8:0] bq_t[$];
  typedef logic [7:0] bq8_t[$];
  logic clk_sys = 0;
  logic resetn = 0;
  logic mode_select_low_pin = 0;
  logic mode_select_high = 1;
  logic host_rx_valid = 0;
  beat_t host_rx = '0;
  logic host_tx_ready = 0;
  logic host_rx_ready, host_tx_valid, host_baud_fixed, air_tx_valid, air_tx_ready;
  logic air_rx_valid, air_rx_ready, air_rate_auto;
  beat_t host_tx, air_tx, air_rx;
  mode_t mode;
  logic [127:0] live_regs, saved_regs;
  logic [8:0] hq[$];
  logic [7:0] v[4];
  logic [7:0] r5;
  bq8_t rb;
  logic stall = 0;
  int seed = 51;
  int n_mismatch = 0;
  int n_compared = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  modem_mode_cmd modem_mode_cmd_i (.clk_sys, .resetn, .mode_select_low_pin, .mode_select_high,
    .host_rx_valid, .host_rx, .host_rx_ready, .host_tx_valid, .host_tx, .host_tx_ready,
    .host_baud_fixed, .air_tx_valid, .air_tx, .air_tx_ready, .air_rx_valid, .air_rx,
    .air_rx_ready, .air_rate_auto, .mode, .live_regs, .saved_regs);
  air_peer_model air_peer_model_i (.clk_sys, .resetn, .air_tx_valid, .air_tx, .air_tx_ready,
    .air_rx_valid, .air_rx, .air_rx_ready);
  // ========================
  // Host side collection; random back-pressure
  always @(negedge clk_sys) if (host_tx_valid === 1'b1 && host_tx_ready === 1'b1) hq.push_back(host_tx);
  always @(posedge clk_sys) host_tx_ready <= #1 !stall && ($random(seed) % 4 != 0);
  // ========================
  // Tasks
  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function automatic bq_t wl(input bq8_t b);
    bq_t r;
    foreach (b[i]) r.push_back({b[i], i == b.size() - 1});
    return r;
  endfunction : wl
  task automatic send(input logic [7:0] d, input logic l);
    logic r;
    host_rx_valid = 1;
    host_rx = '{data: d, last: l};
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      r = host_rx_ready;
      @(posedge clk_sys);
      if (r) break;
      if (i == 2999) begin
        n_mismatch++;
        final_report();
      end
    end
    #1;
  endtask : send
  // Valid stays up between bytes; released one cycle before the next frame
  task automatic frame(input bq8_t b);
    foreach (b[i]) send(b[i], i == b.size() - 1);
    host_rx_valid = 0;
    host_rx.data = ~host_rx.data;
    @(posedge clk_sys);
    #1;
  endtask : frame
  task automatic wait_n(input int air, input int n);
    for (int i = 0; i < 4000 && (air ? air_peer_model_i.txq.size() : hq.size()) < n; i++) @(posedge clk_sys);
    #1;
    if ((air ? air_peer_model_i.txq.size() : hq.size()) < n) begin
      n_mismatch++;
      final_report();
    end
  endtask : wait_n
  task automatic expect_host(input bq_t e);
    wait_n(0, e.size());
    foreach (e[i]) cmp(hq.pop_front(), e[i]);
  endtask : expect_host
  task automatic expect_air(input bq_t e);
    wait_n(1, e.size());
    foreach (e[i]) cmp(air_peer_model_i.txq.pop_front(), e[i]);
  endtask : expect_air
  task automatic err(input bq8_t b);
    frame(b);
    expect_host(wl('{ERR_BYTE, ERR_BYTE, ERR_BYTE}));
  endtask : err
  task automatic set_mode(input logic lo, input logic hi);
    mode_select_low_pin = lo;
    mode_select_high = hi;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : set_mode
  task automatic randq(input int n);
    rb.delete();
    for (int i = 0; i < n; i++) rb.push_back(8'($random(seed)));
  endtask : randq
  task automatic stream(input int n, input logic gen);
    bq_t e;
    randq(n);
    frame(rb);
    foreach (rb[i]) e.push_back({rb[i], i == n - 1 || (gen && i == 54)});
    expect_air(e);
  endtask : stream
  // ========================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 resetn = 1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp(9'(mode), 9'(MODE_CFG));
    cmp(9'(host_baud_fixed), 9'h001);
    air_peer_model_i.inject('{RSP_HEADER, 8'h05, 8'h01, 8'h09});
    repeat (30) @(posedge clk_sys);
    #1;
    cmp(9'(hq.size()), 9'h000);
    r5 = 8'($random(seed));
    frame('{CMD_WRITE, 8'h05, 8'h01});
    repeat (6) @(posedge clk_sys);
    #1;
    cmp(9'(hq.size()), 9'h000);
    frame('{r5});
    expect_host(wl('{RSP_HEADER, 8'h05, 8'h01, r5}));
    cmp({1'b0, saved_regs[47:40]}, {1'b0, r5});
    for (int i = 0; i < 4; i++) v[i] = 8'($random(seed));
    frame('{CMD_TEMP, 8'h00, 8'h04, v[0], v[1], v[2], v[3]});
    expect_host(wl('{RSP_HEADER, 8'h00, 8'h04, v[0], v[1], v[2], v[3]}));
    cmp({1'b0, live_regs[31:24]}, {1'b0, v[3]});
    cmp({1'b0, saved_regs[7:0]}, 9'h000);
    frame('{CMD_READ, 8'h00, 8'h04});
    expect_host(wl('{RSP_HEADER, 8'h00, 8'h04, v[0], v[1], v[2], v[3]}));
    err('{8'h00});
    err('{CMD_READ, 8'h00, 8'h00});
    err('{CMD_READ, 8'h0F, 8'h02});
    err('{CMD_REMOTE, 8'h00});
    frame('{CMD_REMOTE, CMD_REMOTE, CMD_READ, 8'h05, 8'h01});
    expect_air(wl('{CMD_REMOTE, CMD_REMOTE, CMD_READ, 8'h05, 8'h01}));
    air_peer_model_i.inject('{CMD_REMOTE, CMD_REMOTE, RSP_HEADER, 8'h05, 8'h01, r5});
    expect_host(wl('{CMD_REMOTE, CMD_REMOTE, RSP_HEADER, 8'h05, 8'h01, r5}));
    frame('{CMD_REMOTE, CMD_REMOTE, CMD_WRITE, 8'h05, 8'h01, r5});
    expect_air(wl('{CMD_REMOTE, CMD_REMOTE, CMD_WRITE, 8'h05, 8'h01, r5}));
    set_mode(1'b1, 1'b0);
    cmp(9'(mode), 9'(MODE_GEN));
    air_peer_model_i.slow = 1;
    stream(60, 1'b1);
    air_peer_model_i.slow = 0;
    // FIFO fills to its depth while the host stalls, the rest waits at the radio
    stall = 1;
    randq(12);
    air_peer_model_i.inject(rb);
    repeat (40) @(posedge clk_sys);
    #1;
    cmp(9'(air_peer_model_i.rxq.size()), 9'h004);
    stall = 0;
    expect_host(wl(rb));
    set_mode(1'b0, 1'b0);
    cmp(9'(air_rate_auto), 9'h001);
    stream(58, 1'b0);
    set_mode(1'b1, 1'b1);
    frame('{8'h11, 8'h22});
    air_peer_model_i.inject('{8'h33});
    repeat (30) @(posedge clk_sys);
    #1;
    cmp(9'(air_peer_model_i.txq.size() + hq.size()), 9'h000);
    cmp(9'(air_rx_ready), 9'h000);
    final_report();
  end
endmodule : modem_mode_cmd_bench
